// File: dv/bchr_host.sv
// host model: APB configuration master and I/O request source for the header slice
// assumes: zero or more wait states, requests launched just after a rising edge
`default_nettype none

module bchr_host
    import bchr_pkg::*;
(
    input  wire logic          i_clk,
    input  wire logic          i_pready,
    input  wire logic [31:0]   i_prdata,
    input  wire logic          i_pslverr,
    input  wire bchr_io_dec_t  i_io_dec,
    output logic               o_psel,
    output logic               o_penable,
    output logic               o_pwrite,
    output logic [11:0]        o_paddr,
    output logic [31:0]        o_pwdata,
    output logic [3:0]         o_pstrb,
    output bchr_io_req_t       o_io_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 12'h000;
        o_pwdata  = 32'h0000_0000;
        o_pstrb   = 4'h0;
        o_io_req  = '0;
    end

    // ------------------------------------------------------------------------
    // one APB transfer, held until pready is sampled high
    // ------------------------------------------------------------------------
    task automatic apb_xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                            input logic [3:0] st, output logic [31:0] rd, output logic er);
        @(posedge i_clk);
        o_psel    <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite  <= wr;
        o_paddr   <= {idx, 2'b00};
        o_pwdata  <= wd;
        o_pstrb   <= st;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do @(posedge i_clk); while (i_pready !== 1'b1);
        rd = i_prdata;
        er = i_pslverr;
        // released address and data lines must not keep their last value; pwrite and pstrb do
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        o_paddr   <= ~o_paddr;
        o_pwdata  <= ~o_pwdata;
    endtask : apb_xfer

    // ------------------------------------------------------------------------
    // one I/O request pulse, decode taken one cycle later
    // ------------------------------------------------------------------------
    task automatic io_probe(input logic [31:0] a, output bchr_io_dec_t d);
        @(posedge i_clk);
        o_io_req <= '{valid: 1'b1, addr: a};
        @(posedge i_clk);
        o_io_req <= '{valid: 1'b0, addr: ~a};
        @(posedge i_clk);
        d = i_io_dec;
    endtask : io_probe
endmodule : bchr_host

`default_nettype wire

// File: dv/test_bridge_config_header_regs.sv
// self-checking bench of the bridge header slice
// assumes: bchr_host drives every input of the slice except clock and reset
`default_nettype none
`include "bchr_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", nm, e, g); err_total++; end end

module test_bridge_config_header_regs;
    import bchr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         psel, penable, pwrite, pready, pslverr;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata;
    logic [3:0]   pstrb;
    bchr_io_req_t io_req;
    bchr_io_dec_t io_dec;
    int           err_total = 0;
    int           comparisons = 0;
    logic [9:0]   idx_t [12] = '{`BCHR_IDX_CLS, `BCHR_IDX_PLT, `BCHR_IDX_HDR, `BCHR_IDX_SELF_TEST,
        `BCHR_IDX_BASE_ADDRESS_0, `BCHR_IDX_BASE_ADDRESS_1, `BCHR_IDX_PBUS, `BCHR_IDX_SBUS, `BCHR_IDX_SUBUS,
        `BCHR_IDX_SLT, `BCHR_IDX_IOB, `BCHR_IDX_IOL};
    // reset, after all ones written, after all zeros written
    logic [7:0]   exp_t [3][12] = '{
        '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF1, 8'h01},
        '{8'hFF, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hF1, 8'hF1},
        '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01}};
    logic [31:0]  io_a [6] = '{32'h0000_1FFF, 32'h0000_2000, 32'h0000_3FFF, 32'h0000_4000,
        32'h0001_2000, 32'h0000_2ABC};
    logic         io_f [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

    initial begin
        forever #5 clk = ~clk;
    end

    bchr_regs u_dut (.I_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
        .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_IO_REQ(io_req),
        .O_IO_DEC(io_dec));

    bchr_host u_host (.i_clk(clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr),
        .i_io_dec(io_dec), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb), .o_io_req(io_req));

    task automatic end_sim();
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] st);
        logic [31:0] rd;
        logic        er;
        u_host.apb_xfer(1'b1, idx, {24'hFFFFFF, d}, st, rd, er);
    endtask : wr

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e, input logic ee);
        logic [31:0] rd;
        logic        er;
        u_host.apb_xfer(1'b0, idx, 32'h0000_0000, 4'h0, rd, er);
        `CHK($sformatf("data %0h", idx), {24'h000000, e}, rd)
        `CHK($sformatf("error %0h", idx), ee, er)
    endtask : rd_chk

    task automatic sweep(input int k, input logic [7:0] d);
        for (int i = 0; i < 12; i++) if (k > 0) wr(idx_t[i], d, 4'hF);
        for (int i = 0; i < 12; i++) rd_chk(idx_t[i], exp_t[k][i], 1'b0);
    endtask : sweep

    initial begin
        bchr_io_dec_t dec;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        sweep(0, 8'h00);
        sweep(1, 8'hFF);
        sweep(2, 8'h00);
        wr(`BCHR_IDX_UNLOCK, 8'h01, 4'hF);
        wr(`BCHR_IDX_IOB, 8'h00, 4'hF);
        rd_chk(`BCHR_IDX_IOB, 8'h00, 1'b0);
        rd_chk(`BCHR_IDX_IOL, 8'h00, 1'b0);
        wr(`BCHR_IDX_IOB, 8'h2F, 4'hF);
        wr(`BCHR_IDX_UNLOCK, 8'h00, 4'hF);
        rd_chk(`BCHR_IDX_IOL, 8'h01, 1'b0);
        wr(`BCHR_IDX_CLS, 8'h5A, 4'hE);
        rd_chk(`BCHR_IDX_CLS, 8'h00, 1'b0);
        wr(`BCHR_IDX_CLS, 8'h5A, 4'hF);
        wr(10'h011, 8'hA5, 4'hF);
        rd_chk(10'h011, 8'h00, 1'b1);
        rd_chk(`BCHR_IDX_CLS, 8'h5A, 1'b0);
        wr(`BCHR_IDX_IOL, 8'h30, 4'hF);
        for (int i = 0; i < 6; i++) begin
            u_host.io_probe(io_a[i], dec);
            `CHK("io valid", 1'b1, dec.valid)
            `CHK($sformatf("fwd %h", io_a[i]), io_f[i], dec.forward)
        end
        wr(`BCHR_IDX_IOB, 8'h40, 4'hF);
        u_host.io_probe(32'h0000_3000, dec);
        `CHK("fwd empty", 1'b0, dec.forward)
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule : test_bridge_config_header_regs

`default_nettype wire

// File: inc/bchr_defs.svh
// register indices, field positions and reset values of the bridge header slice
// assumes: byte address on the bus is four times the register index
`ifndef BCHR_DEFS_SVH
`define BCHR_DEFS_SVH

// ----------------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------------
`define BCHR_IDX_CLS     10'h00C
`define BCHR_IDX_PLT     10'h00D
`define BCHR_IDX_HDR     10'h00E
`define BCHR_IDX_SELF_TEST    10'h00F
`define BCHR_IDX_BASE_ADDRESS_0    10'h010
`define BCHR_IDX_BASE_ADDRESS_1    10'h014
`define BCHR_IDX_PBUS    10'h018
`define BCHR_IDX_SBUS    10'h019
`define BCHR_IDX_SUBUS   10'h01A
`define BCHR_IDX_SLT     10'h01B
`define BCHR_IDX_IOB     10'h01C
`define BCHR_IDX_IOL     10'h01D
`define BCHR_IDX_UNLOCK  10'h03F

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define BCHR_CAP_BIT     0
`define BCHR_WIN_LSB     4
`define BCHR_HDR_CODE    8'h01
`define BCHR_CLS_RST     8'h00
`define BCHR_BUS_RST     8'h00
`define BCHR_CAP_RST     1'h1
`define BCHR_IOB_RST     4'hF
`define BCHR_IOL_RST     4'h0
`define BCHR_LOW_FILL    12'hFFF
`define BCHR_LOW_ZERO    12'h000

`endif

// File: inc/bchr_pkg.sv
// types shared by the bridge header slice
// assumes: nothing beyond a SystemVerilog compiler
`default_nettype none

package bchr_pkg;
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } bchr_io_req_t;

    typedef struct packed {
        logic valid;
        logic forward;
    } bchr_io_dec_t;
endpackage : bchr_pkg

`default_nettype wire

// File: logic/bchr_regs.sv
// type 1 bridge header slice: cache line, bus numbers, I/O window, APB slave
// assumes: APB master on I_CLK, I/O requests synchronous to I_CLK
//
// Overview of operation
// - cache line size: RW, reset zero, no effect
// - primary latency timer reads zero
// - header type reads 0x01
// - self test register reads zero
// - both base address registers read zero
// - primary bus number RW, reset zero, inert
// - secondary bus number RW, reset zero
// - subordinate bus number RW, reset zero
// - secondary latency timer reads zero
// - I/O width flag resets one, lock-gated writes
// - limit bit 0 mirrors width flag
// - base bits 7:4 RW, reset 0xF
// - limit bits 7:4 RW, reset zero, low 0xFFF
// - forward I/O inside base-limit window
`default_nettype none
`include "bchr_defs.svh"

module bchr_regs
    import bchr_pkg::*;
(
    input  wire logic         I_CLK,
    input  wire logic         I_ARST_N,
    input  wire logic         I_PSEL,
    input  wire logic         I_PENABLE,
    input  wire logic         I_PWRITE,
    input  wire logic [11:0]  I_PADDR,
    input  wire logic [31:0]  I_PWDATA,
    input  wire logic [3:0]   I_PSTRB,
    output logic              O_PREADY,
    output logic [31:0]       O_PRDATA,
    output logic              O_PSLVERR,
    input  wire bchr_io_req_t I_IO_REQ,
    output bchr_io_dec_t      O_IO_DEC
);

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    logic [9:0]  idx;
    logic        setup;
    logic        wr;
    logic        hit_d;
    logic [7:0]  rd_d;
    logic [7:0]  wb;

    logic [7:0]  cache_line_size_field_q;
    logic [7:0]  upstream_bus_id_q;
    logic [7:0]  downstream_bus_id_q;
    logic [7:0]  highest_bus_id_q;
    logic        io_addressing_width_flag_q;
    logic [3:0]  io_window_low_bits_q;
    logic [3:0]  io_window_high_bits_q;
    logic        unlock_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        fwd_d;
    bchr_io_dec_t dec_q;

    assign idx   = I_PADDR[11:2];
    assign setup = I_PSEL & ~I_PENABLE;
    assign wr    = I_PSEL & I_PENABLE & I_PWRITE & I_PSTRB[0];
    assign wb    = I_PWDATA[7:0];

    // zero-wait slave: access phase always completes in one cycle
    assign O_PREADY  = 1'b1;
    assign O_PRDATA  = prdata_q;
    assign O_PSLVERR = pslverr_q;
    assign O_IO_DEC  = dec_q;

    always_comb begin
        hit_d = 1'b1;
        rd_d  = 8'h00;
        unique case (idx)
            `BCHR_IDX_CLS:    rd_d = cache_line_size_field_q;
            `BCHR_IDX_PLT:    rd_d = 8'h00;
            `BCHR_IDX_HDR:    rd_d = `BCHR_HDR_CODE;
            `BCHR_IDX_SELF_TEST:   rd_d = 8'h00;
            `BCHR_IDX_BASE_ADDRESS_0:   rd_d = 8'h00;
            `BCHR_IDX_BASE_ADDRESS_1:   rd_d = 8'h00;
            `BCHR_IDX_PBUS:   rd_d = upstream_bus_id_q;
            `BCHR_IDX_SBUS:   rd_d = downstream_bus_id_q;
            `BCHR_IDX_SUBUS:  rd_d = highest_bus_id_q;
            `BCHR_IDX_SLT:    rd_d = 8'h00;
            `BCHR_IDX_IOB:    rd_d = {io_window_low_bits_q, 3'h0,
                                      io_addressing_width_flag_q};
            `BCHR_IDX_IOL:    rd_d = {io_window_high_bits_q, 3'h0,
                                      io_addressing_width_flag_q};
            `BCHR_IDX_UNLOCK: rd_d = {7'h00, unlock_q};
            default:          hit_d = 1'b0;
        endcase
    end

    // read data and error captured in setup, presented in access
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= {24'h00_0000, rd_d};
            pslverr_q <= ~hit_d;
        end
    end

    // ------------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cache_line_size_field_q <= `BCHR_CLS_RST;
        end else if (wr && idx == `BCHR_IDX_CLS) begin
            cache_line_size_field_q <= wb;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            upstream_bus_id_q   <= `BCHR_BUS_RST;
            downstream_bus_id_q <= `BCHR_BUS_RST;
            highest_bus_id_q    <= `BCHR_BUS_RST;
        end else if (wr) begin
            if (idx == `BCHR_IDX_PBUS) begin
                upstream_bus_id_q <= wb;
            end
            if (idx == `BCHR_IDX_SBUS) begin
                downstream_bus_id_q <= wb;
            end
            if (idx == `BCHR_IDX_SUBUS) begin
                highest_bus_id_q <= wb;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            unlock_q <= 1'b0;
        end else if (wr && idx == `BCHR_IDX_UNLOCK) begin
            unlock_q <= wb[0];
        end
    end

    // width flag only moves while the unlock bit is set
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            io_addressing_width_flag_q <= `BCHR_CAP_RST;
        end else if (wr && unlock_q && idx == `BCHR_IDX_IOB) begin
            io_addressing_width_flag_q <= wb[`BCHR_CAP_BIT];
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            io_window_low_bits_q  <= `BCHR_IOB_RST;
            io_window_high_bits_q <= `BCHR_IOL_RST;
        end else if (wr) begin
            if (idx == `BCHR_IDX_IOB) begin
                io_window_low_bits_q <= wb[7:`BCHR_WIN_LSB];
            end
            if (idx == `BCHR_IDX_IOL) begin
                io_window_high_bits_q <= wb[7:`BCHR_WIN_LSB];
            end
        end
    end

    // ------------------------------------------------------------------------
    // I/O window decode
    // ------------------------------------------------------------------------
    // upper 16 address bits must be zero; upper window halves live elsewhere
    always_comb begin
        fwd_d = (I_IO_REQ.addr[31:16] == 16'h0000)
              && (I_IO_REQ.addr[15:0] >= {io_window_low_bits_q, `BCHR_LOW_ZERO})
              && (I_IO_REQ.addr[15:0] <= {io_window_high_bits_q, `BCHR_LOW_FILL});
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            dec_q <= '0;
        end else begin
            dec_q.valid   <= I_IO_REQ.valid;
            dec_q.forward <= I_IO_REQ.valid & fwd_d;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);

    sequence rd_of(logic [9:0] r);
        setup && idx == r;
    endsequence

    cls_write_a: assert property (wr && idx == `BCHR_IDX_CLS |=> rd_of(`BCHR_IDX_CLS)
        |=> O_PRDATA[7:0] == $past(wb, 2)) else $error("cls readback");
    plt_zero_a: assert property (rd_of(`BCHR_IDX_PLT) |=> O_PRDATA == 32'h0)
        else $error("plt nonzero");
    hdr_code_a: assert property (rd_of(`BCHR_IDX_HDR) |=> O_PRDATA == 32'h1)
        else $error("header code");
    self_test_zero_a: assert property (rd_of(`BCHR_IDX_SELF_TEST) |=> O_PRDATA == 32'h0)
        else $error("self_test nonzero");
    bar_zero_a: assert property ((rd_of(`BCHR_IDX_BASE_ADDRESS_0) or rd_of(`BCHR_IDX_BASE_ADDRESS_1))
        |=> O_PRDATA == 32'h0 && !O_PSLVERR) else $error("bar nonzero");
    pbus_hold_a: assert property (!(wr && idx == `BCHR_IDX_PBUS)
        |=> $stable(upstream_bus_id_q)) else $error("pbus moved");
    sbus_write_a: assert property (wr && idx == `BCHR_IDX_SBUS
        |=> downstream_bus_id_q == $past(wb)) else $error("sbus write");
    subus_write_a: assert property (wr && idx == `BCHR_IDX_SUBUS
        |=> highest_bus_id_q == $past(wb)) else $error("subus write");
    slt_zero_a: assert property (rd_of(`BCHR_IDX_SLT) |=> O_PRDATA == 32'h0)
        else $error("slt nonzero");
    cap_locked_a: assert property (!unlock_q |=> $stable(io_addressing_width_flag_q))
        else $error("cap moved locked");
    cap_mirror_a: assert property (rd_of(`BCHR_IDX_IOL)
        |=> O_PRDATA[0] == io_addressing_width_flag_q) else $error("cap mirror");
    iob_write_a: assert property (wr && idx == `BCHR_IDX_IOB
        |=> io_window_low_bits_q == $past(wb[7:4])) else $error("iob write");
    iol_write_a: assert property (wr && idx == `BCHR_IDX_IOL
        |=> io_window_high_bits_q == $past(wb[7:4])) else $error("iol write");
    fwd_window_a: assert property (I_IO_REQ.valid
        |=> O_IO_DEC.valid && O_IO_DEC.forward == $past(fwd_d))
        else $error("forward decision");
    rsvd_zero_a: assert property ((rd_of(`BCHR_IDX_IOB) or rd_of(`BCHR_IDX_IOL))
        |=> O_PRDATA[3:1] == 3'h0) else $error("reserved bits");

    fwd_hit_c: cover property (O_IO_DEC.valid && O_IO_DEC.forward);
    cap_clear_c: cover property (!io_addressing_width_flag_q);
    unmapped_c: cover property (I_PSEL && I_PENABLE && O_PSLVERR);

endmodule : bchr_regs

`default_nettype wire
